// ===== hw/urs_pkg.sv
/*
  package of the receive status block: register map, field positions,
  reset values, receiver timing counts and the buffered character carrier.
  assumes a 32-bit classic wishbone slave with word-aligned registers.
*/
package urs_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] URS_STATUS_CONTROL_OFS = 8'h00;
  localparam logic [7:0] URS_RX_DATA_OFS = 8'h04;
  localparam logic [7:0] URS_CONFIG_OFS = 8'h08;
  localparam logic [7:0] URS_IRQ_STATUS_OFS = 8'h0C;
  localparam logic [7:0] URS_IRQ_MASK_OFS = 8'h10;

  // ==========================================================
  // status/control fields
  localparam int URS_BIT_RXDA = 0;
  localparam int URS_BIT_OVERRUN_ERROR_FLAG = 1;
  localparam int URS_BIT_FRAMING_ERROR_FLAG = 2;
  localparam int URS_BIT_PARITY_ERROR_FLAG = 3;
  localparam int URS_BIT_IDLE = 4;
  localparam int URS_BIT_ADEN = 5;
  localparam int URS_BIT_ISEL_LO = 6;

  // config fields: bits 1:0 data format, bits 31:16 baud divisor
  localparam int URS_BIT_FMT_LO = 0;
  localparam int URS_BIT_DIV_LO = 16;

  // irq status fields
  localparam int URS_IRQ_RX = 0;
  localparam int URS_IRQ_OVR = 1;
  localparam int URS_IRQ_W = 2;

  // ==========================================================
  // reset values and sizes
  localparam logic [15:0] URS_DIV_RESET = 16'h0015;
  localparam logic [1:0] URS_FMT_RESET = 2'h0;
  localparam int URS_FIFO_DEPTH = 4;
  localparam logic [2:0] URS_FIFO_FULL = 3'h4;
  localparam logic [2:0] URS_FIFO_3Q = 3'h3;
  localparam int URS_OVERSAMPLE = 16;
  localparam logic [3:0] URS_MID_TICK = 4'h7;

  // data formats
  localparam logic [1:0] URS_FMT_8N = 2'h0;
  localparam logic [1:0] URS_FMT_8E = 2'h1;
  localparam logic [1:0] URS_FMT_8O = 2'h2;
  localparam logic [1:0] URS_FMT_9N = 2'h3;

  // interrupt select codes
  localparam logic [1:0] URS_ISEL_FULL = 2'h3;
  localparam logic [1:0] URS_ISEL_3Q = 2'h2;

  typedef struct packed {
    logic [8:0] data;
    logic parity_err;
    logic framing_err;
  } urs_char_t;

  typedef struct packed {
    logic [7:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic stb;
    logic cyc;
  } urs_wb_req_t;

endpackage : urs_pkg

// ===== hw/urs_rx_status.sv
/*
  receive side of a serial port: oversampled receiver, four-character
  receive fifo with per-character error flags, status/control register,
  overrun handling and masked level interrupt on classic wishbone.
  assumes rx_i is asynchronous and idles high; one clock, sync reset.
*/
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - ninth bit set marks address; filter others
// - address detect only active in nine-bit format
// - idle flag high unless character in progress
// - parity flag shows head character parity error
// - framing flag shows head character stop error
// - overrun set when full buffer loses character
// - clearing overrun empties buffer and shift register
// - data available while buffer holds characters
// - buffer holds four characters, full at four
// - irq select: full, three, or every character
module urs_rx_status (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire urs_pkg::urs_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial line and interrupt
  input wire logic rx_i,
  output logic irq_o
);
  import urs_pkg::*;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} urs_rx_state_t;

  // ==========================================================
  // bus decode
  logic acc;
  logic wr;
  logic rd_data;
  assign acc = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  assign wr = acc && wb_req_i.we;
  assign rd_data = acc && !wb_req_i.we && wb_req_i.adr == URS_RX_DATA_OFS;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= acc;
  end

  // ==========================================================
  // control registers
  logic aden_q;
  logic [1:0] isel_q;
  logic [1:0] fmt_q;
  logic [15:0] div_q;
  logic [URS_IRQ_W-1:0] irq_mask_q;
  logic overrun_error_flag_q;
  logic overrun_error_flag_clr;
  assign overrun_error_flag_clr = wr && wb_req_i.adr == URS_STATUS_CONTROL_OFS && wb_req_i.sel[0]
                    && !wb_req_i.dat[URS_BIT_OVERRUN_ERROR_FLAG] && overrun_error_flag_q;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      aden_q <= 1'b0;
      isel_q <= 2'h0;
      fmt_q <= URS_FMT_RESET;
      div_q <= URS_DIV_RESET;
      irq_mask_q <= '0;
    end
    else if (wr && wb_req_i.adr == URS_STATUS_CONTROL_OFS && wb_req_i.sel[0])
    begin
      aden_q <= wb_req_i.dat[URS_BIT_ADEN];
      isel_q <= wb_req_i.dat[URS_BIT_ISEL_LO +: 2];
    end
    else if (wr && wb_req_i.adr == URS_CONFIG_OFS)
    begin
      if (wb_req_i.sel[0])
        fmt_q <= wb_req_i.dat[URS_BIT_FMT_LO +: 2];
      if (wb_req_i.sel[2] && wb_req_i.sel[3])
        div_q <= wb_req_i.dat[URS_BIT_DIV_LO +: 16];
    end
    else if (wr && wb_req_i.adr == URS_IRQ_MASK_OFS && wb_req_i.sel[0])
      irq_mask_q <= wb_req_i.dat[URS_IRQ_W-1:0];
  end

  // ==========================================================
  // oversample tick divider
  logic [15:0] div_cnt_q;
  logic tick;
  assign tick = (div_cnt_q == 16'h0000);
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || tick)
      div_cnt_q <= div_q;
    else
      div_cnt_q <= div_cnt_q - 16'h0001;
  end

  // ==========================================================
  // line synchroniser
  logic rx_s1_q;
  logic rx_s2_q;
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end
    else
    begin
      rx_s1_q <= rx_i;
      rx_s2_q <= rx_s1_q;
    end
  end

  // ==========================================================
  // receive shift register
  urs_rx_state_t st_q;
  logic [3:0] os_q;
  logic [3:0] bit_q;
  logic [9:0] sh_q;
  logic done;
  logic nine;
  logic par_on;
  logic [3:0] nbits;
  urs_char_t rx_char;
  assign nine = (fmt_q == URS_FMT_9N);
  assign par_on = (fmt_q == URS_FMT_8E) || (fmt_q == URS_FMT_8O);
  // eight data bits plus parity occupy the same slot count as nine bits
  assign nbits = (nine || par_on) ? 4'h9 : 4'h8;
  assign done = (st_q == RX_STOP) && tick && (os_q == 4'(URS_OVERSAMPLE - 1));

  always_comb
  begin
    rx_char.data = sh_q[9:1];
    if (!nine && !par_on)
      rx_char.data = {1'b0, sh_q[9:2]};
    else if (par_on)
      rx_char.data = {1'b0, sh_q[8:1]};
    rx_char.parity_err = par_on && ((^sh_q[9:1]) != (fmt_q == URS_FMT_8O));
    rx_char.framing_err = !rx_s2_q;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || overrun_error_flag_clr)
    begin
      st_q <= RX_IDLE;
      os_q <= 4'h0;
      bit_q <= 4'h0;
      sh_q <= '0;
    end
    else if (tick)
    begin
      os_q <= os_q + 4'h1;
      case (st_q)
        RX_IDLE:
        begin
          os_q <= 4'h0;
          if (!rx_s2_q)
            st_q <= RX_START;
        end
        RX_START:
          if (os_q == URS_MID_TICK)
          begin
            os_q <= 4'h0;
            bit_q <= 4'h0;
            st_q <= rx_s2_q ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (os_q == 4'(URS_OVERSAMPLE - 1))
          begin
            sh_q <= {rx_s2_q, sh_q[9:1]};
            bit_q <= bit_q + 4'h1;
            if (bit_q == nbits - 4'h1)
              st_q <= RX_STOP;
          end
        RX_STOP:
          // character is taken from the shift register in this same tick
          if (os_q == 4'(URS_OVERSAMPLE - 1))
            st_q <= RX_IDLE;
        default:
          st_q <= RX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // receive fifo
  urs_char_t mem_q [URS_FIFO_DEPTH];
  logic [1:0] wp_q;
  logic [1:0] rp_q;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic full;
  logic accept;
  logic push;
  logic pop;
  assign full = (cnt_q == URS_FIFO_FULL);
  // in address mode only address characters enter the buffer
  assign accept = !(aden_q && nine) || rx_char.data[8];
  assign push = done && accept && !full && !overrun_error_flag_q;
  assign pop = rd_data && cnt_q != 3'h0;
  assign cnt_d = cnt_q + {2'h0, push} - {2'h0, pop};

  always_ff @(posedge core_clk_i)
  begin
    if (push)
      mem_q[wp_q] <= rx_char;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || overrun_error_flag_clr)
    begin
      wp_q <= 2'h0;
      rp_q <= 2'h0;
      cnt_q <= 3'h0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 2'h1;
      if (pop)
        rp_q <= rp_q + 2'h1;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // overrun flag; software can only clear it
  logic ovr_ev;
  assign ovr_ev = done && accept && full;
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      overrun_error_flag_q <= 1'b0;
    else if (ovr_ev)
      overrun_error_flag_q <= 1'b1;
    else if (overrun_error_flag_clr)
      overrun_error_flag_q <= 1'b0;
  end

  // ==========================================================
  // interrupts
  logic rx_ev;
  logic [URS_IRQ_W-1:0] irq_st_q;
  logic [URS_IRQ_W-1:0] irq_clr;
  always_comb
  begin
    case (isel_q)
      URS_ISEL_FULL: rx_ev = push && cnt_d == URS_FIFO_FULL;
      URS_ISEL_3Q: rx_ev = push && !pop && cnt_d == URS_FIFO_3Q;
      default: rx_ev = push;
    endcase
  end
  assign irq_clr = (wr && wb_req_i.adr == URS_IRQ_STATUS_OFS && wb_req_i.sel[0])
                   ? wb_req_i.dat[URS_IRQ_W-1:0] : '0;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      irq_st_q <= '0;
    else
      // set wins over a same-cycle clear
      irq_st_q <= (irq_st_q & ~irq_clr) | {ovr_ev, rx_ev};
  end
  assign irq_o = |(irq_st_q & irq_mask_q);

  // ==========================================================
  // read data
  urs_char_t head;
  logic [31:0] sta;
  assign head = mem_q[rp_q];
  always_comb
  begin
    sta = '0;
    sta[URS_BIT_RXDA] = (cnt_q != 3'h0);
    sta[URS_BIT_OVERRUN_ERROR_FLAG] = overrun_error_flag_q;
    sta[URS_BIT_FRAMING_ERROR_FLAG] = (cnt_q != 3'h0) && head.framing_err;
    sta[URS_BIT_PARITY_ERROR_FLAG] = (cnt_q != 3'h0) && head.parity_err;
    sta[URS_BIT_IDLE] = (st_q == RX_IDLE);
    sta[URS_BIT_ADEN] = aden_q;
    sta[URS_BIT_ISEL_LO +: 2] = isel_q;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      wb_dat_o <= '0;
    else if (acc && !wb_req_i.we)
    begin
      if (wb_req_i.adr == URS_STATUS_CONTROL_OFS)
        wb_dat_o <= sta;
      else if (wb_req_i.adr == URS_RX_DATA_OFS)
        wb_dat_o <= (cnt_q != 3'h0) ? {23'h0, head.data} : 32'h0;
      else if (wb_req_i.adr == URS_CONFIG_OFS)
        wb_dat_o <= {div_q, 14'h0, fmt_q};
      else if (wb_req_i.adr == URS_IRQ_STATUS_OFS)
        wb_dat_o <= {30'h0, irq_st_q};
      else if (wb_req_i.adr == URS_IRQ_MASK_OFS)
        wb_dat_o <= {30'h0, irq_mask_q};
      else
        wb_dat_o <= 32'h0;
    end
  end

  // ==========================================================
  // checks
  a_overrun_sets: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ovr_ev |=> overrun_error_flag_q) else $error("overrun not flagged");
  a_flush_on_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
    overrun_error_flag_clr && !ovr_ev |=> cnt_q == 3'h0 && st_q == RX_IDLE)
    else $error("clear did not flush");
  a_depth_limit: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cnt_q <= URS_FIFO_FULL) else $error("fifo over depth");
  a_no_push_full: assert property (@(posedge core_clk_i) disable iff (rst_i)
    full && !pop && !overrun_error_flag_clr |=> full) else $error("full fifo changed");
  a_addr_filter: assert property (@(posedge core_clk_i) disable iff (rst_i)
    done && aden_q && nine && !rx_char.data[8] && !overrun_error_flag_clr |=> $stable(cnt_q) || $past(pop))
    else $error("data char passed filter");
  a_full_irq: assert property (@(posedge core_clk_i) disable iff (rst_i)
    isel_q == URS_ISEL_FULL && rx_ev |=> cnt_q == URS_FIFO_FULL)
    else $error("full irq wrong count");
  a_idle_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $fell(sta[URS_BIT_IDLE]) |-> $past(!rx_s2_q)) else $error("idle left without start");
  a_data_avail: assert property (@(posedge core_clk_i) disable iff (rst_i)
    push |=> sta[URS_BIT_RXDA]) else $error("data available missing");
endmodule : urs_rx_status
`default_nettype wire

// ===== testbench/urs_ser_tx.sv
/*
  serial transmitter model that drives the receive line of the block.
  assumes the bench has set a bit time of BIT_CLKS core clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module urs_ser_tx #(
  parameter int BIT_CLKS = 32
) (
  // clock and line
  input wire logic clk_i,
  output logic line_o
);
  // ====================
  // frame generation
  // idle level is the line's pull-up level
  initial line_o = 1'b1;

  task automatic bit_out(input logic b);
    begin
      @(posedge clk_i);
      line_o <= b;
      repeat (BIT_CLKS - 1) @(posedge clk_i);
    end
  endtask : bit_out

  // par: 0 none, 1 even, 2 odd; bad flips parity, stp is the stop level
  task automatic send(input logic [8:0] d, input int nb, input int par,
                      input logic bad, input logic stp);
    begin
      bit_out(1'b0);
      for (int i = 0; i < nb; i++) bit_out(d[i]);
      if (par != 0) bit_out(((par == 2) ^ (^d[7:0])) ^ bad);
      bit_out(stp);
      // one idle bit so a bad stop never runs into the next start
      bit_out(1'b1);
    end
  endtask : send
endmodule : urs_ser_tx
`default_nettype wire

// ===== testbench/urs_rx_status_tb.sv
/*
  testbench of the receive status block: wishbone tasks and sequences.
  assumes the serial model runs at divisor 1, i.e. 32 clocks per bit.
*/
`timescale 1ns/1ps
`default_nettype none
module urs_rx_status_tb;
  import urs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  urs_wb_req_t req = '0;
  logic [31:0] rdat;
  logic [31:0] v;
  logic ack;
  logic irq;
  logic rx;
  int error_cnt = 0;
  int check_count = 0;
  logic [1:0] isel_tab [3] = '{2'h1, 2'h2, 2'h3};
  int cnt_tab [3] = '{1, 3, 4};

  always #12.5 clk = ~clk;

  urs_rx_status urs_rx_status_inst (
    .core_clk_i(clk), .rst_i(rst), .wb_req_i(req), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rx_i(rx), .irq_o(irq));
  urs_ser_tx #(.BIT_CLKS(32)) urs_ser_tx_inst (.clk_i(clk), .line_o(rx));

  // ====================
  // helpers
  task automatic summarize();
    begin
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    begin
      check_count++;
      if (seen !== exp)
      begin
        error_cnt++;
        $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      @(posedge clk);
      req <= '{adr: a, dat: d, sel: 4'hF, we: we, stb: 1'b1, cyc: 1'b1};
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (ack !== 1'b1 && n < 50);
      v = rdat;
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
      if (n >= 50)
      begin
        chk({31'h0, ack}, 32'h1, "ack");
        summarize();
      end
    end
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    begin
      wb(1'b0, a, 32'h0);
      chk(v, exp, what);
    end
  endtask : rd

  task automatic chk_irq(input logic exp);
    begin
      // irq is combinational from registers: look once edge updates land
      @(negedge clk);
      chk({31'h0, irq}, {31'h0, exp}, "irq");
    end
  endtask : chk_irq

  // ====================
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'h10, "status");
    wb(1'b1, 8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'h0, "unmapped");
    wb(1'b1, 8'h08, 32'h0001_0001);
    rd(8'h08, 32'h0001_0001, "config");
    $display("test reset done");
    fork
      urs_ser_tx_inst.send(9'h055, 8, 1, 1'b0, 1'b1);
      begin
        repeat (100) @(posedge clk);
        rd(8'h00, 32'h00, "status busy");
      end
    join
    urs_ser_tx_inst.send(9'h0A5, 8, 1, 1'b1, 1'b1);
    urs_ser_tx_inst.send(9'h03C, 8, 1, 1'b0, 1'b0);
    rd(8'h00, 32'h11, "status");
    rd(8'h04, 32'h55, "data");
    rd(8'h00, 32'h19, "status");
    rd(8'h04, 32'hA5, "data");
    rd(8'h00, 32'h15, "status");
    rd(8'h04, 32'h3C, "data");
    rd(8'h00, 32'h10, "status");
    $display("test errors done");
    wb(1'b1, 8'h08, 32'h0001_0000);
    wb(1'b1, 8'h10, 32'h1);
    for (int k = 0; k < 3; k++)
    begin
      wb(1'b1, 8'h00, {24'h0, isel_tab[k], 6'h0});
      for (int j = 1; j <= cnt_tab[k]; j++)
      begin
        urs_ser_tx_inst.send(9'(j), 8, 0, 1'b0, 1'b1);
        chk_irq(j == cnt_tab[k]);
      end
      wb(1'b1, 8'h0C, 32'h1);
      chk_irq(1'b0);
      if (k < 2)
        for (int j = 1; j <= cnt_tab[k]; j++) rd(8'h04, 32'(j), "data");
    end
    urs_ser_tx_inst.send(9'h0EE, 8, 0, 1'b0, 1'b1);
    rd(8'h00, 32'hD3, "status full");
    rd(8'h0C, 32'h2, "irq status");
    chk_irq(1'b0);
    wb(1'b1, 8'h10, 32'h3);
    rd(8'h10, 32'h3, "irq mask");
    chk_irq(1'b1);
    wb(1'b1, 8'h0C, 32'h3);
    chk_irq(1'b0);
    wb(1'b1, 8'h00, 32'hC0);
    rd(8'h00, 32'hD0, "status flushed");
    wb(1'b1, 8'h00, 32'hC2);
    rd(8'h00, 32'hD0, "status no set");
    $display("test irq and overrun done");
    wb(1'b1, 8'h08, 32'h0001_0003);
    wb(1'b1, 8'h00, 32'h20);
    urs_ser_tx_inst.send(9'h0AA, 9, 0, 1'b0, 1'b1);
    urs_ser_tx_inst.send(9'h155, 9, 0, 1'b0, 1'b1);
    rd(8'h00, 32'h31, "status addr");
    rd(8'h04, 32'h155, "data addr");
    rd(8'h00, 32'h30, "status addr");
    wb(1'b1, 8'h08, 32'h0001_0000);
    urs_ser_tx_inst.send(9'h033, 8, 0, 1'b0, 1'b1);
    rd(8'h04, 32'h33, "data 8 bit");
    $display("test address detect done");
    wb(1'b1, 8'h08, 32'h0001_0002);
    urs_ser_tx_inst.send(9'h0C3, 8, 2, 1'b0, 1'b1);
    urs_ser_tx_inst.send(9'h0C3, 8, 2, 1'b1, 1'b1);
    rd(8'h00, 32'h31, "status odd");
    rd(8'h04, 32'hC3, "data odd");
    rd(8'h00, 32'h39, "status odd");
    rd(8'h04, 32'hC3, "data odd");
    $display("test odd parity done");
    summarize();
  end
endmodule : urs_rx_status_tb
`default_nettype wire
